// ===== hdl/tcr_regs.v
// Transmit control and hardware configuration register bank on APB
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "tcr_map.vh"

module tcr_regs #(
  parameter LED_SLOW_CYC = `TCR_LED_SLOW_MS * 1000 * `TCR_CLK_MHZ,
  parameter LED_FAST_CYC = `TCR_LED_FAST_US * `TCR_CLK_MHZ
) (
  // Clock and resets
  input  wire        pclk,
  input  wire        presetn,
  input  wire        lite_reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Transmit engine
  input  wire        tx_frame_active,
  input  wire        tx_path_empty,
  output reg         tx_run,
  output reg         tx_fifo_flush,
  // Receive and USB side
  input  wire        eeprom_present,
  input  wire        rx_fifo_empty,
  input  wire        in_token,
  input  wire        sync_lost,
  input  wire        led_activity,
  output reg         in_send_zlp,
  output reg         in_send_nak,
  output reg         use_desc_ram,
  output reg  [1:0]  rx_pad_bytes,
  output reg         bulk_out_stall,
  output reg         led_out,
  // Interrupt
  output reg         irq
);

  // ========================================================================
  // Input synchronisers for pin-level inputs
  // Only the second stage feeds logic, so a metastable first stage settles
  reg [1:0] eep_sync_r;
  reg [1:0] lrst_sync_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eep_sync_r <= 2'h0;
    end else begin
      eep_sync_r <= {eep_sync_r[0], eeprom_present};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lrst_sync_r <= 2'h0;
    end else begin
      lrst_sync_r <= {lrst_sync_r[0], lite_reset};
    end
  end

  wire eep_det = eep_sync_r[1];
  wire lrst    = lrst_sync_r[1];

  // ========================================================================
  // APB decode; a write lands only at the edge that completes the transfer
  // Addresses are compared whole; aliases are not decoded
  function hit;
    input [11:0] addr;
    input [11:0] offs;
    begin
      hit = (addr == offs);
    end
  endfunction

  wire        acc     = psel & penable;
  wire        wr      = acc & pready & pwrite;
  wire        wr_tx   = wr & hit(paddr, `TCR_OFF_TXCTL);
  wire        wr_hw   = wr & hit(paddr, `TCR_OFF_HWCFG);
  wire        wr_ist  = wr & hit(paddr, `TCR_OFF_INTSTS);
  wire        wr_imk  = wr & hit(paddr, `TCR_OFF_INTMSK);
  wire        mapped  = hit(paddr, `TCR_OFF_TXCTL) |
                        hit(paddr, `TCR_OFF_HWCFG) |
                        hit(paddr, `TCR_OFF_INTSTS) |
                        hit(paddr, `TCR_OFF_INTMSK);

  // ========================================================================
  // Transmit control state
  reg  tx_on_r;
  reg  tx_stop_r;
  reg  flush_r;
  reg  stop_done_r;
  // Halt means no frame in flight and nothing left in the data path
  wire halted   = ~tx_frame_active & tx_path_empty;
  wire stop_end = tx_stop_r & halted;

  // Clearing on halt wins over a simultaneous software write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_on_r <= 1'b0;
    end else if (lrst) begin
      tx_on_r <= 1'b0;
    end else if (stop_end) begin
      tx_on_r <= 1'b0;
    end else if (wr_tx) begin
      tx_on_r <= pwdata[`TCR_TX_ON];
    end
  end

  // Stop request is sticky until the transmitter drains
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_stop_r <= 1'b0;
    end else if (lrst) begin
      tx_stop_r <= 1'b0;
    end else if (stop_end) begin
      tx_stop_r <= 1'b0;
    end else if (wr_tx & ~tx_stop_r) begin
      tx_stop_r <= pwdata[`TCR_TX_STOP];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_r     <= 1'b0;
      stop_done_r <= 1'b0;
    end else if (lrst) begin
      flush_r     <= 1'b0;
      stop_done_r <= 1'b0;
    end else begin
      // Flush is a one-cycle strobe; the bit itself always reads zero
      flush_r     <= wr_tx & pwdata[`TCR_TX_FLUSH];
      stop_done_r <= stop_end;
    end
  end

  // ========================================================================
  // Hardware configuration; protected fields only see power-on reset
  reg       emu_en_r;
  reg       protect_r;
  reg       nak_r;
  reg       led_byp_r;
  reg [1:0] rx_off_r;
  reg       stall_dis_r;

  // Protection shields both itself and the emulation bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emu_en_r <= 1'b0;
    end else if (lrst & ~protect_r) begin
      emu_en_r <= 1'b0;
    end else if (wr_hw & ~lrst) begin
      emu_en_r <= pwdata[`TCR_HW_EMU_EN];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_r <= 1'b0;
    end else if (lrst & ~protect_r) begin
      protect_r <= 1'b0;
    end else if (wr_hw & ~lrst) begin
      protect_r <= pwdata[`TCR_HW_PROTECT];
    end
  end

  // Unprotected fields go back to zero on every reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_r       <= 1'b0;
      stall_dis_r <= 1'b0;
    end else if (lrst) begin
      nak_r       <= 1'b0;
      stall_dis_r <= 1'b0;
    end else if (wr_hw) begin
      nak_r       <= pwdata[`TCR_HW_EMPTY_NAK];
      stall_dis_r <= pwdata[`TCR_HW_STALL_DIS];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_byp_r <= 1'b0;
      rx_off_r  <= 2'h0;
    end else if (lrst) begin
      led_byp_r <= 1'b0;
      rx_off_r  <= 2'h0;
    end else if (wr_hw) begin
      led_byp_r <= pwdata[`TCR_HW_LED_BYP];
      rx_off_r  <= pwdata[`TCR_HW_OFF_HI:`TCR_HW_OFF_LO];
    end
  end

  // ========================================================================
  // Interrupt status and mask
  reg ist_r;
  reg imk_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= 1'b0;
    end else if (stop_done_r) begin
      // Set beats a simultaneous write-one-to-clear
      ist_r <= 1'b1;
    end else if (wr_ist & pwdata[`TCR_INT_TXSTOP]) begin
      ist_r <= 1'b0;
    end
  end

  // Mask register only gates the interrupt line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imk_r <= 1'b0;
    end else if (wr_imk) begin
      imk_r <= pwdata[`TCR_INT_TXSTOP];
    end
  end

  // ========================================================================
  // Activity LED blink timer: one on phase then one off phase per burst
  // Bypass only shortens the phases; the pattern stays the same
  localparam [2:0] LED_IDLE = 3'h1;
  localparam [2:0] LED_ON   = 3'h2;
  localparam [2:0] LED_OFF  = 3'h4;

  reg  [2:0]  led_st_r;
  reg  [2:0]  led_st_nxt;
  reg  [31:0] led_cnt_r;
  reg         led_on_r;
  wire [31:0] led_lim  = led_byp_r ? LED_FAST_CYC : LED_SLOW_CYC;
  wire        led_last = (led_cnt_r >= led_lim - 32'h00000001);

  always @* begin
    led_st_nxt = led_st_r;
    case (led_st_r)
      LED_IDLE: begin
        if (led_activity)
          led_st_nxt = LED_ON;
      end
      LED_ON: begin
        if (led_last)
          led_st_nxt = LED_OFF;
      end
      LED_OFF: begin
        if (led_last)
          led_st_nxt = LED_IDLE;
      end
      default: led_st_nxt = LED_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_st_r  <= LED_IDLE;
      led_cnt_r <= `TCR_ZERO32;
      led_on_r  <= 1'b0;
    end else begin
      led_st_r <= led_st_nxt;
      led_on_r <= (led_st_nxt == LED_ON);
      // Counter restarts at every phase change
      if (led_st_nxt != led_st_r)
        led_cnt_r <= `TCR_ZERO32;
      else if (led_st_r != LED_IDLE)
        led_cnt_r <= led_cnt_r + 32'h00000001;
    end
  end

  // ========================================================================
  // Register read mux; reserved bits read zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = `TCR_ZERO32;
    case (paddr)
      `TCR_OFF_TXCTL: begin
        rd_mux[`TCR_TX_ON]   = tx_on_r;
        rd_mux[`TCR_TX_STOP] = tx_stop_r;
      end
      `TCR_OFF_HWCFG: begin
        rd_mux[`TCR_HW_EMU_EN]    = emu_en_r;
        rd_mux[`TCR_HW_PROTECT]   = protect_r;
        rd_mux[`TCR_HW_EMPTY_NAK] = nak_r;
        rd_mux[`TCR_HW_LED_BYP]   = led_byp_r;
        rd_mux[`TCR_HW_OFF_HI:`TCR_HW_OFF_LO] = rx_off_r;
        rd_mux[`TCR_HW_STALL_DIS] = stall_dis_r;
      end
      `TCR_OFF_INTSTS: rd_mux[`TCR_INT_TXSTOP] = ist_r;
      `TCR_OFF_INTMSK: rd_mux[`TCR_INT_TXSTOP] = imk_r;
      default: rd_mux = `TCR_ERR_DATA;
    endcase
  end

  // ========================================================================
  // APB response: one wait state, answer in the cycle after access begins
  // Unmapped offsets answer with an error and zero data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `TCR_ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      // Read data is frozen one edge early so it stands with pready
      if (psel & ~pwrite & ~pready)
        prdata <= rd_mux;
    end
  end

  // ========================================================================
  // Transmit engine outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_run        <= 1'b0;
      tx_fifo_flush <= 1'b0;
    end else begin
      tx_run        <= tx_on_r;
      tx_fifo_flush <= flush_r;
    end
  end

  // ========================================================================
  // USB side outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_send_zlp    <= 1'b0;
      in_send_nak    <= 1'b0;
      use_desc_ram   <= 1'b0;
      rx_pad_bytes   <= 2'h0;
      bulk_out_stall <= 1'b0;
    end else begin
      // Token answered only while the FIFO is empty
      in_send_zlp    <= in_token & rx_fifo_empty & ~nak_r;
      in_send_nak    <= in_token & rx_fifo_empty & nak_r;
      // Descriptor source follows the emulation bit only without an EEPROM
      use_desc_ram   <= emu_en_r & ~eep_det;
      rx_pad_bytes   <= rx_off_r;
      bulk_out_stall <= sync_lost & ~stall_dis_r;
    end
  end

  // ========================================================================
  // LED and interrupt outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_out <= 1'b0;
      irq     <= 1'b0;
    end else begin
      led_out <= led_on_r;
      irq     <= ist_r & imk_r;
    end
  end

endmodule

// ===== hdl/tcr_map.vh
// Register map, field positions and timing constants of the config bank
`ifndef TCR_MAP_VH
`define TCR_MAP_VH

// ==========================================================================
// Register byte offsets
`define TCR_OFF_TXCTL      12'h010
`define TCR_OFF_HWCFG      12'h014
`define TCR_OFF_INTSTS     12'h018
`define TCR_OFF_INTMSK     12'h01C

// ==========================================================================
// Transmit control fields
`define TCR_TX_FLUSH       0
`define TCR_TX_STOP        1
`define TCR_TX_ON          2

// ==========================================================================
// Hardware configuration fields
`define TCR_HW_STALL_DIS   8
`define TCR_HW_OFF_LO      9
`define TCR_HW_OFF_HI      10
`define TCR_HW_LED_BYP     11
`define TCR_HW_EMPTY_NAK   12
`define TCR_HW_PROTECT     15
`define TCR_HW_EMU_EN      16

// ==========================================================================
// Interrupt status fields
`define TCR_INT_TXSTOP     17

// ==========================================================================
// Activity LED timing
`define TCR_LED_SLOW_MS    80
`define TCR_LED_FAST_US    15
`define TCR_CLK_MHZ        100

`define TCR_ZERO32         32'h00000000
`define TCR_ERR_DATA       32'h00000000

`endif

// ===== testbench/tcr_regs_chk.sv
// Concurrent checks on the ports of the config register bank
`timescale 1ns/1ns
// ==========================================================
// Checker
module tcr_regs_chk (
  // Clock, reset and APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Transmit and USB side
  input wire        tx_run,
  input wire        tx_fifo_flush,
  input wire        in_token,
  input wire        rx_fifo_empty,
  input wire        in_send_zlp,
  input wire        in_send_nak,
  input wire        sync_lost,
  input wire        bulk_out_stall,
  input wire [1:0]  rx_pad_bytes,
  input wire        eeprom_present,
  input wire        use_desc_ram
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_rd(a);
    pready && !pwrite && paddr == a;
  endsequence
  chk_unmapped_err: assert property (s_setup ##0 !pwrite &&
    !(paddr inside {12'h010, 12'h014, 12'h018, 12'h01C})
    |=> pslverr && prdata == 0) else $error("unmapped read not refused");
  chk_txctl_resv: assert property (s_rd(12'h010) |->
    prdata[31:3] == 0 && !prdata[0]) else $error("txctl reserved set");
  chk_hwcfg_resv: assert property (s_rd(12'h014) |->
    prdata[31:17] == 0 && prdata[14:13] == 0) else $error("hwcfg resv");
  chk_flush_cause: assert property (tx_fifo_flush |-> $past(psel &&
    penable && pready && pwrite && paddr == 12'h010 && pwdata[0], 2))
    else $error("flush without write");
  chk_empty_reply: assert property (in_token && rx_fifo_empty |=>
    in_send_zlp ^ in_send_nak) else $error("no single empty reply");
  chk_stall_sync: assert property (!sync_lost |=>
    !bulk_out_stall) else $error("stall without sync loss");
  chk_eeprom_mask: assert property (eeprom_present [*4] |=>
    !use_desc_ram) else $error("emulation used with eeprom");
  chk_pad_follow: assert property (pready && pwrite &&
    paddr == 12'h014 |-> ##2 rx_pad_bytes == $past(pwdata[10:9], 2))
    else $error("pad count not taken");
  chk_run_follow: assert property (pready && pwrite &&
    paddr == 12'h010 |-> ##2 tx_run == $past(pwdata[2], 2))
    else $error("run not taken");
endmodule

bind tcr_regs tcr_regs_chk i_tcr_regs_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_run(tx_run), .tx_fifo_flush(tx_fifo_flush), .in_token(in_token),
  .rx_fifo_empty(rx_fifo_empty), .in_send_zlp(in_send_zlp),
  .in_send_nak(in_send_nak), .sync_lost(sync_lost),
  .bulk_out_stall(bulk_out_stall), .rx_pad_bytes(rx_pad_bytes),
  .eeprom_present(eeprom_present), .use_desc_ram(use_desc_ram));

// ===== testbench/tcr_regs_tb_top.sv
// Self-checking bench for the config register bank
`timescale 1ns/1ns
// ==========================================================
// Bench
module tcr_regs_tb_top;
  reg         pclk, presetn, lite_reset, psel, penable, pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg         tx_frame_active, tx_path_empty, eeprom_present, er;
  reg         rx_fifo_empty, in_token, sync_lost, led_activity;
  wire [31:0] prdata;
  wire        pready, pslverr, tx_run, tx_fifo_flush, in_send_zlp;
  wire        in_send_nak, use_desc_ram, bulk_out_stall, led_out, irq;
  wire [1:0]  rx_pad_bytes;
  integer     error_cnt, samples_checked;

  // Short LED counts keep the run brief
  tcr_regs #(.LED_SLOW_CYC(50), .LED_FAST_CYC(5)) i_tcr_regs (
    .pclk(pclk), .presetn(presetn), .lite_reset(lite_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_frame_active(tx_frame_active), .tx_path_empty(tx_path_empty),
    .tx_run(tx_run), .tx_fifo_flush(tx_fifo_flush),
    .eeprom_present(eeprom_present), .rx_fifo_empty(rx_fifo_empty),
    .in_token(in_token), .sync_lost(sync_lost), .led_activity(led_activity),
    .in_send_zlp(in_send_zlp), .in_send_nak(in_send_nak),
    .use_desc_ram(use_desc_ram), .rx_pad_bytes(rx_pad_bytes),
    .bulk_out_stall(bulk_out_stall), .led_out(led_out), .irq(irq));

  task report_and_stop;
    $display("Compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input [31:0] g, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n = n + 1) @(posedge pclk);
    if (n == 20) begin
      $display("[FAIL] %0t no ready", $time);
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Empty-queue IN token; reply flags are {nak, zlp}
  task tok(input [1:0] e);
    @(posedge pclk) in_token <= 1'b1;
    @(posedge pclk) in_token <= 1'b0;
    @(negedge pclk) chk(e, {in_send_nak, in_send_zlp});
  endtask

  // Lite reset is synchronised inside, so hold it several cycles
  task lite;
    @(posedge pclk) lite_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    lite_reset <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    {presetn, lite_reset, psel, penable, pwrite, in_token} = 0;
    {tx_frame_active, tx_path_empty, eeprom_present, led_activity} = 0;
    {paddr, pwdata, sync_lost, rx_fifo_empty, error_cnt} = 0;
    samples_checked = 0;
    rx_fifo_empty = 1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h010, 0);
    chk(rd, 0);
    apb(0, 12'h020, 0);
    chk({rd[30:0], er}, 1);
    apb(1, 12'h014, 32'hFFFFFFFF);
    apb(0, 12'h014, 0);
    chk(rd, 32'h00019F00);
    @(negedge pclk) chk({rx_pad_bytes, use_desc_ram}, 7);
    tok(2'b10);
    @(posedge pclk);
    sync_lost <= 1'b1;
    eeprom_present <= 1'b1;
    repeat (5) @(negedge pclk);
    chk({bulk_out_stall, use_desc_ram}, 0);
    lite;
    apb(0, 12'h014, 0);
    chk(rd, 32'h00018000);
    apb(1, 12'h014, 32'h00000200);
    repeat (3) @(negedge pclk);
    chk({bulk_out_stall, rx_pad_bytes}, 5);
    tok(2'b01);
    lite;
    apb(0, 12'h014, 0);
    chk(rd, 0);
    // Stop while a frame is still in flight
    tx_frame_active <= 1'b1;
    apb(1, 12'h01C, 32'h00020000);
    apb(1, 12'h010, 32'h4);
    repeat (2) @(negedge pclk);
    chk(tx_run, 1);
    apb(1, 12'h010, 32'h6);
    apb(1, 12'h010, 32'h4);
    apb(0, 12'h010, 0);
    chk(rd, 6);
    tx_frame_active <= 1'b0;
    tx_path_empty <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(0, 12'h010, 0);
    chk(rd, 0);
    apb(0, 12'h018, 0);
    chk({rd[30:0], irq}, 32'h00040001);
    apb(1, 12'h018, 32'h00020000);
    repeat (2) @(negedge pclk);
    chk(irq, 0);
    apb(1, 12'h010, 32'h1);
    repeat (2) @(negedge pclk);
    chk(tx_fifo_flush, 1);
    @(negedge pclk);
    chk(tx_fifo_flush, 0);
    apb(0, 12'h010, 0);
    chk(rd, 0);
    // One activity burst: on phase, then dark in the off phase
    @(posedge pclk) led_activity <= 1'b1;
    @(posedge pclk) led_activity <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(led_out, 1);
    repeat (60) @(negedge pclk);
    chk(led_out, 0);
    report_and_stop;
  end
endmodule
